// File: rtl/nic_pkg.sv
// Shared constants, types and helpers for the nested interrupt controller
package nic_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_VEC = 14;
    localparam int NUM_LEVELS = 4;
    localparam int EXT_PINS = 8;
    localparam int EXT_VEC = 2;
    localparam int PRIO_REGS = 4;

    // ------------------------------------------------------------
    // Vector map
    // ------------------------------------------------------------
    localparam logic [15:0] VEC_RESET_ADDR = 16'hFFFE;
    localparam logic [15:0] VEC_TRAP_ADDR = 16'hFFFC;
    localparam logic [15:0] VEC_BASE_ADDR = 16'hFFFA;
    localparam logic [15:0] VEC_LAST_ADDR = 16'hFFE0;

    // ------------------------------------------------------------
    // Level codes, high bit first, and condition code positions
    // ------------------------------------------------------------
    localparam logic [1:0] LVL0_CODE = 2'h2;
    localparam logic [1:0] LVL1_CODE = 2'h1;
    localparam logic [1:0] LVL2_CODE = 2'h0;
    localparam logic [1:0] LVL3_CODE = 2'h3;
    localparam int CC_PRIO_HI_POS = 5;
    localparam int CC_PRIO_LO_POS = 3;

    // ------------------------------------------------------------
    // Reset values and defaults
    // ------------------------------------------------------------
    localparam logic [7:0] PRIO_REG_RESET = 8'hFF;
    localparam logic [3:0] PRIO_RO_BITS = 4'hF;
    localparam logic [13:0] WAKE_CAP_DEFAULT = 14'h00BE;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {NIC_BOOT, NIC_RUN, NIC_OFFER} nic_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [3:0] vec;
        logic stack;
        logic nmi;
    } nic_take_t;

    // Level code to numeric rank, 0 lowest
    function automatic logic [1:0] prio_rank(input logic [1:0] code);
        return {~(code[1] ^ code[0]), code[0]};
    endfunction
endpackage

// File: rtl/nic_sync.sv
// Two-flop synchroniser for asynchronous pin inputs
module nic_sync #(
    parameter int WIDTH = 8
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    // ------------------------------------------------------------
    // First stage feeds only the second
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // nic_sync

// File: rtl/nic_src_latch.sv
// Pending latch for one maskable interrupt source
module nic_src_latch (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic req,
    input wire logic edge_mode,
    input wire logic clr_service,
    input wire logic clr_seq,
    output logic pending
);
    logic prev;
    logic set;
    logic clr;

    // ------------------------------------------------------------
    // Latch
    // ------------------------------------------------------------
    assign set = edge_mode ? (req & ~prev) : req;
    assign clr = clr_seq | (edge_mode & clr_service);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            prev <= 1'b0;
        end else begin
            prev <= req;
        end
    end

    // Set beats clear so a fresh edge is never lost
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pending <= 1'b0;
        end else begin
            pending <= set | (pending & ~clr); // [R11] [R18] [R21]
        end
    end

    AST_SET_WINS: assert property (@(posedge sys_clk) disable iff (reset) // [R11]
        set |=> pending)
        else $error("new request lost in latch");

    AST_CLEAR_SEQ: assert property (@(posedge sys_clk) disable iff (reset) // [R21]
        clr && !set |=> !pending)
        else $error("latch not cleared");
endmodule // nic_src_latch

// File: rtl/nic_top.sv
// Nested priority interrupt controller beside an 8-bit CPU core
//
// Contract
// R01 - Four nesting levels, fourteen hardware vector slots, plus reset and trap.
// R02 - Vectors sit from FFE0h to FFFFh in hardware priority order.
// R03 - Current level is condition code bits 5 and 3, the masking threshold.
// R04 - Service starts only after the current instruction completes.
// R05 - Entry stacks program counter, index, accumulator and condition code.
// R06 - Entry loads the current level from the serviced vector's field.
// R07 - After stacking, vector address loads program counter and fetch follows.
// R08 - Return restores stacked registers including both level bits.
// R09 - Codes: 10 level 0, 01 level 1, 00 level 2, 11 level 3.
// R10 - Highest software level wins; ties go to highest hardware priority.
// R11 - Unserved requests stay latched until they become the winner.
// R12 - Reset and trap count as highest software priority.
// R13 - Non-maskables ignore the level, stack except reset, set level 3.
// R14 - Non-maskable sources can leave HALT.
// R15 - Trap instruction is serviced through the normal entry sequence.
// R16 - Reset is highest; first routine runs at level 3.
// R17 - Maskable served only if enabled and above current level.
// R18 - Edge requests latch, clear on service entry, and can wake HALT.
// R19 - Selected pins of a shared external line are ORed.
// R20 - Peripheral raises request only while flag and enable are set.
// R21 - Peripheral clear sequence discards that source's pending latch.
// R22 - All wake WAIT; only capable wake HALT and are served first.
// R23 - Writing the level 0 code leaves that field unchanged.
// R24 - Priority registers reset to all ones, level 3.
// R25 - Raising a field while served and still pending re-enters it.
// R26 - Offer vector at instruction boundary; acknowledge when stacking starts.
module nic_top #(
    parameter logic [13:0] WAKE_CAP = nic_pkg::WAKE_CAP_DEFAULT
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [nic_pkg::EXT_PINS-1:0] ext_pin,
    input wire logic [nic_pkg::EXT_PINS-1:0] ext_sel,
    input wire logic [nic_pkg::NUM_VEC-1:0] ext_irq_sensitivity_reg,
    input wire logic [nic_pkg::NUM_VEC-1:0] periph_req,
    input wire logic [nic_pkg::NUM_VEC-1:0] periph_clear,
    input wire logic [nic_pkg::NUM_VEC-1:0] src_enable,
    input wire logic prio_wr_en,
    input wire logic [1:0] prio_wr_sel,
    input wire logic [7:0] prio_wr_data,
    input wire logic cpu_boundary,
    input wire logic cpu_trap,
    input wire logic cpu_ack,
    input wire logic return_from_interrupt,
    input wire logic [7:0] cpu_cc_restore,
    input wire logic cc_sw_load,
    input wire logic [1:0] cc_sw_bits,
    input wire logic wait_mode,
    input wire logic halt_mode,
    output logic [31:0] vector_priority_regs,
    output logic take_req,
    output nic_pkg::nic_take_t take,
    output logic prio_hi_bit,
    output logic prio_lo_bit,
    output logic [nic_pkg::NUM_VEC-1:0] pending,
    output logic wake
);
    nic_pkg::nic_state_t state;
    logic [nic_pkg::EXT_PINS-1:0] ext_sync;
    logic ext_line;
    logic [nic_pkg::NUM_VEC-1:0] src_line;
    logic [nic_pkg::NUM_VEC-1:0] svc_clr;
    logic [nic_pkg::NUM_VEC-1:0] allow;
    logic [nic_pkg::NUM_VEC-1:0] cand;
    logic trap_pend;
    logic after_halt;
    logic accept;
    logic best_found;
    logic [3:0] best_vec;
    logic [1:0] best_rank;
    logic [1:0] cur_rank;
    logic [1:0] served_field;

    // ------------------------------------------------------------
    // External line and source latches
    // ------------------------------------------------------------
    nic_sync #(
        .WIDTH(nic_pkg::EXT_PINS)
    ) u_ext_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .d(ext_pin),
        .q(ext_sync)
    );

    assign ext_line = |(ext_sync & ext_sel); // [R19]

    always_comb begin
        src_line = periph_req; // [R20]
        src_line[nic_pkg::EXT_VEC] = periph_req[nic_pkg::EXT_VEC] | ext_line;
    end

    assign accept = (state == nic_pkg::NIC_OFFER) && cpu_ack;

    always_comb begin
        svc_clr = '0;
        if (accept && !take.nmi) begin
            svc_clr[take.vec] = 1'b1; // [R18]
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < nic_pkg::NUM_VEC; gi++) begin : g_src
            nic_src_latch u_latch (
                .sys_clk(sys_clk),
                .reset(reset),
                .req(src_line[gi]),
                .edge_mode(ext_irq_sensitivity_reg[gi]),
                .clr_service(svc_clr[gi]),
                .clr_seq(periph_clear[gi]),
                .pending(pending[gi])
            ); // [R11] [R21]
        end
    endgenerate

    // ------------------------------------------------------------
    // Priority registers
    // ------------------------------------------------------------
    // Level 0 is refused per field, so the main level stays unique
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            vector_priority_regs <= {nic_pkg::PRIO_REGS{nic_pkg::PRIO_REG_RESET}}; // [R24]
        end else if (prio_wr_en) begin
            for (int f = 0; f < 4; f++) begin
                if (prio_wr_data[2*f +: 2] != nic_pkg::LVL0_CODE) begin // [R23]
                    vector_priority_regs[8*prio_wr_sel + 2*f +: 2] <= prio_wr_data[2*f +: 2];
                end
            end
            vector_priority_regs[31:28] <= nic_pkg::PRIO_RO_BITS;
        end
    end

    // ------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------
    assign cur_rank = nic_pkg::prio_rank({prio_hi_bit, prio_lo_bit}); // [R03] [R09]
    // After HALT only wake-capable sources may go first
    assign allow = (halt_mode || after_halt) ? WAKE_CAP : '1; // [R22]
    assign cand = pending & src_enable & allow; // [R17]

    // Strict compare keeps the lower index on ties; raising the field of the
    // running vector above the level it loaded re-enters it naturally
    always_comb begin
        best_found = 1'b0;
        best_vec = 4'h0;
        best_rank = cur_rank;
        for (int i = 0; i < nic_pkg::NUM_VEC; i++) begin // [R01]
            if (cand[i] && (nic_pkg::prio_rank(vector_priority_regs[2*i +: 2]) > best_rank)) begin
                best_found = 1'b1; // [R10] [R17] [R25]
                best_vec = 4'(i);
                best_rank = nic_pkg::prio_rank(vector_priority_regs[2*i +: 2]);
            end
        end
    end

    assign served_field = vector_priority_regs[2*take.vec +: 2];

    // ------------------------------------------------------------
    // Trap and HALT tracking
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            trap_pend <= 1'b0;
        end else begin
            trap_pend <= cpu_trap | (trap_pend & ~(accept && take.nmi && take.stack)); // [R15]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            after_halt <= 1'b0;
        end else begin
            after_halt <= halt_mode | (after_halt & ~accept); // [R22]
        end
    end

    // Wake is a request for the clock, not for service
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wake <= 1'b0;
        end else begin
            wake <= (wait_mode || halt_mode) && best_found; // [R14] [R18] [R22]
        end
    end

    // ------------------------------------------------------------
    // Service sequencer
    // ------------------------------------------------------------
    // The choice is frozen once offered; a later winner waits for the next boundary
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state <= nic_pkg::NIC_BOOT;
            take_req <= 1'b0;
            take <= '0;
        end else begin
            unique case (state)
                nic_pkg::NIC_BOOT: begin
                    take_req <= 1'b1;
                    take <= '{addr: nic_pkg::VEC_RESET_ADDR, vec: 4'h0, stack: 1'b0,
                              nmi: 1'b1}; // [R13] [R16]
                    state <= nic_pkg::NIC_OFFER;
                end
                nic_pkg::NIC_RUN: begin
                    if (cpu_boundary && trap_pend) begin // [R04] [R12] [R26]
                        take_req <= 1'b1;
                        take <= '{addr: nic_pkg::VEC_TRAP_ADDR, vec: 4'h0, stack: 1'b1,
                                  nmi: 1'b1}; // [R13] [R15]
                        state <= nic_pkg::NIC_OFFER;
                    end else if (cpu_boundary && best_found) begin // [R04] [R26]
                        take_req <= 1'b1;
                        take <= '{addr: nic_pkg::VEC_BASE_ADDR - {11'h000, best_vec, 1'b0},
                                  vec: best_vec, stack: 1'b1, nmi: 1'b0}; // [R02] [R05] [R07]
                        state <= nic_pkg::NIC_OFFER;
                    end
                end
                nic_pkg::NIC_OFFER: begin
                    if (cpu_ack) begin // [R26]
                        take_req <= 1'b0;
                        state <= nic_pkg::NIC_RUN;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Current level bits
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            {prio_hi_bit, prio_lo_bit} <= nic_pkg::LVL3_CODE; // [R16]
        end else if (accept) begin // [R06] [R13]
            {prio_hi_bit, prio_lo_bit} <= take.nmi ? nic_pkg::LVL3_CODE : served_field;
        end else if (return_from_interrupt) begin
            prio_hi_bit <= cpu_cc_restore[nic_pkg::CC_PRIO_HI_POS]; // [R08]
            prio_lo_bit <= cpu_cc_restore[nic_pkg::CC_PRIO_LO_POS];
        end else if (cc_sw_load) begin
            {prio_hi_bit, prio_lo_bit} <= cc_sw_bits;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_PRIO_RESET: assert property (@(posedge sys_clk) // [R24]
        reset |=> vector_priority_regs == 32'hFFFFFFFF)
        else $error("priority registers not all ones after reset");

    AST_LVL0_REFUSED: assert property (@(posedge sys_clk) disable iff (reset) // [R23]
        prio_wr_en && prio_wr_sel == 2'h0 && prio_wr_data[1:0] == nic_pkg::LVL0_CODE
        |=> vector_priority_regs[1:0] == $past(vector_priority_regs[1:0]))
        else $error("level 0 code was stored");

    AST_BOOT_OFFER: assert property (@(posedge sys_clk) // [R16]
        $past(reset) && !reset |=> take_req && take.addr == nic_pkg::VEC_RESET_ADDR
        && !take.stack && {prio_hi_bit, prio_lo_bit} == nic_pkg::LVL3_CODE)
        else $error("reset vector not offered at level 3");

    AST_OFFER_BOUNDARY: assert property (@(posedge sys_clk) disable iff (reset) // [R04]
        $rose(take_req) && $past(state) == nic_pkg::NIC_RUN |-> $past(cpu_boundary))
        else $error("offer raised off an instruction boundary");

    AST_OFFER_HOLD: assert property (@(posedge sys_clk) disable iff (reset) // [R26]
        take_req && !cpu_ack |=> take_req && $stable(take))
        else $error("offer dropped or changed before acknowledge");

    AST_NMI_LEVEL3: assert property (@(posedge sys_clk) disable iff (reset) // [R13]
        accept && take.nmi |=> {prio_hi_bit, prio_lo_bit} == nic_pkg::LVL3_CODE)
        else $error("non-maskable entry did not set level 3");

    AST_ENTRY_LEVEL: assert property (@(posedge sys_clk) disable iff (reset) // [R06]
        accept && !take.nmi |=> {prio_hi_bit, prio_lo_bit} == $past(served_field))
        else $error("entry level not taken from vector field");

    AST_ABOVE_LEVEL: assert property (@(posedge sys_clk) disable iff (reset) // [R17]
        $rose(take_req) && !take.nmi && $past(state) == nic_pkg::NIC_RUN
        |-> $past(best_rank) > $past(cur_rank) && $past(best_vec) == take.vec
        && (($past(src_enable) >> take.vec) & 14'h0001) != 14'h0000)
        else $error("maskable offered at or below current level");

    AST_RETURN_FROM_INTERRUPT_RESTORE: assert property (@(posedge sys_clk) disable iff (reset) // [R08]
        return_from_interrupt && !accept |=> {prio_hi_bit, prio_lo_bit}
        == {$past(cpu_cc_restore[5]), $past(cpu_cc_restore[3])})
        else $error("return did not restore level bits");

    AST_TRAP_FIRST: assert property (@(posedge sys_clk) disable iff (reset) // [R12]
        state == nic_pkg::NIC_RUN && cpu_boundary && trap_pend
        |=> take_req && take.nmi && take.addr == nic_pkg::VEC_TRAP_ADDR)
        else $error("trap not taken first");

    AST_VEC_ADDR: assert property (@(posedge sys_clk) disable iff (reset) // [R02]
        take_req && !take.nmi |-> take.addr == 16'hFFFA - {11'h000, take.vec, 1'b0}
        && take.addr >= nic_pkg::VEC_LAST_ADDR)
        else $error("vector address mismatch");

    AST_HALT_FIRST: assert property (@(posedge sys_clk) disable iff (reset) // [R22]
        $rose(take_req) && !take.nmi && $past(halt_mode || after_halt) |-> WAKE_CAP[take.vec])
        else $error("first service after halt not wake-capable");
endmodule // nic_top

// File: dv/nic_cpu_model.sv
// CPU core sequencer model facing the interrupt controller
module nic_cpu_model (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic slow,
    input wire logic asleep,
    input wire logic take_req,
    input wire nic_pkg::nic_take_t take,
    output logic cpu_boundary,
    output logic cpu_ack,
    output nic_pkg::nic_take_t last_take,
    output int n_taken
);
    timeunit 1ns;
    timeprecision 1ps;
    int wait_cnt;
    int stack_cnt;
    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (reset) begin
            cpu_boundary <= 1'b0;
            cpu_ack <= 1'b0;
            last_take <= '0;
            n_taken <= 0;
            wait_cnt <= 0;
            stack_cnt <= 0;
        end else if (cpu_ack) begin
            // Stacking takes a few cycles, so no boundary then
            cpu_ack <= 1'b0;
            cpu_boundary <= 1'b0;
            last_take <= take;
            n_taken <= n_taken + 1;
            stack_cnt <= 3;
            wait_cnt <= 0;
        end else begin
            // Multi-cycle instructions; a sleeping core has no boundary
            cpu_boundary <= (stack_cnt == 0) && !asleep && !cpu_boundary;
            if (stack_cnt != 0) begin
                stack_cnt <= stack_cnt - 1;
            end
            if (take_req && wait_cnt >= (slow ? 4 : 0)) begin
                cpu_ack <= 1'b1;
            end else if (take_req) begin
                wait_cnt <= wait_cnt + 1;
            end
        end
    end
endmodule // nic_cpu_model

// File: dv/tb_top.sv
// Self-checking bench for the nested interrupt controller
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] ext_pin = 8'h00;
    logic [7:0] ext_sel = 8'h00;
    logic [13:0] sens = 14'h3FFF;
    logic [13:0] preq = 14'h0000;
    logic [13:0] pclr = 14'h0000;
    logic [13:0] src_en = 14'h3FFF;
    logic wr_en = 1'b0;
    logic [1:0] wr_sel = 2'h0;
    logic [7:0] wr_data = 8'h00;
    logic trap = 1'b0;
    logic ret_pulse = 1'b0;
    logic [7:0] restore_byte = 8'h00;
    logic sw_load = 1'b0;
    logic [1:0] sw_bits = 2'h0;
    logic wait_mode = 1'b0;
    logic halt_mode = 1'b0;
    logic slow = 1'b0;
    logic cpu_boundary, cpu_ack, take_req, prio_hi_bit, prio_lo_bit, wake;
    logic [31:0] prio_regs;
    logic [13:0] pending;
    logic [1:0] level;
    nic_pkg::nic_take_t take, last_take;
    int n_taken;
    int n_fail = 0;
    int checks = 0;
    assign level = {prio_hi_bit, prio_lo_bit};
    always #10 sys_clk = ~sys_clk;
    nic_top dut (.sys_clk(sys_clk), .reset(reset), .ext_pin(ext_pin), .ext_sel(ext_sel),
        .ext_irq_sensitivity_reg(sens), .periph_req(preq), .periph_clear(pclr),
        .src_enable(src_en), .prio_wr_en(wr_en), .prio_wr_sel(wr_sel),
        .prio_wr_data(wr_data), .cpu_boundary(cpu_boundary), .cpu_trap(trap),
        .cpu_ack(cpu_ack), .return_from_interrupt(ret_pulse), .cpu_cc_restore(restore_byte),
        .cc_sw_load(sw_load), .cc_sw_bits(sw_bits), .wait_mode(wait_mode),
        .halt_mode(halt_mode), .vector_priority_regs(prio_regs), .take_req(take_req),
        .take(take), .prio_hi_bit(prio_hi_bit), .prio_lo_bit(prio_lo_bit),
        .pending(pending), .wake(wake));
    nic_cpu_model cpu (.sys_clk(sys_clk), .reset(reset), .slow(slow),
        .asleep(halt_mode | wait_mode), .take_req(take_req), .take(take),
        .cpu_boundary(cpu_boundary), .cpu_ack(cpu_ack), .last_take(last_take),
        .n_taken(n_taken));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic prio_wr(input logic [1:0] sel, input logic [7:0] data);
        wr_en = 1'b1;
        wr_sel = sel;
        wr_data = data;
        step(1);
        wr_en = 1'b0;
        step(1);
    endtask
    task automatic sw_level(input logic [1:0] bits);
        sw_load = 1'b1;
        sw_bits = bits;
        step(1);
        sw_load = 1'b0;
        step(1);
    endtask
    // Popped byte carries the level in bits 5 and 3
    task automatic ret_to(input logic [1:0] bits);
        ret_pulse = 1'b1;
        restore_byte = {2'b00, bits[1], 1'b0, bits[0], 3'b000};
        step(1);
        ret_pulse = 1'b0;
        step(1);
    endtask
    task automatic clr(input int v);
        pclr[v] = 1'b1;
        step(1);
        pclr = 14'h0000;
        step(1);
    endtask
    task automatic take_is(input logic [15:0] addr, input logic stk, input logic nmi);
        int seen;
        seen = n_taken;
        for (int i = 0; i < 60 && n_taken == seen; i++) step(1);
        check(32'(n_taken - seen), 32'h1);
        check({last_take.addr, last_take.stack, last_take.nmi}, {addr, stk, nmi});
    endtask
    task automatic done(input string name);
        $display("test %s finished, mismatches so far %0d", name, n_fail);
    endtask
    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        #200000;
        n_fail++;
        finish_test();
    end
    initial begin
        step(8);
        check(prio_regs, 32'hFFFFFFFF);
        check(level, nic_pkg::LVL3_CODE);
        check({pending, take_req, wake}, 16'h0000);
        reset = 1'b0;
        take_is(16'hFFFE, 1'b0, 1'b1);
        step(1);
        check(level, nic_pkg::LVL3_CODE);
        done("reset");
        prio_wr(2'h0, 8'hCF);
        prio_wr(2'h0, 8'h64);
        check(prio_regs[7:0], 8'h44);
        prio_wr(2'h0, 8'h46);
        check(prio_regs[7:0], 8'h44);
        prio_wr(2'h3, 8'h00);
        check(prio_regs[31:8], 24'hF0FFFF);
        done("priority");
        sw_level(nic_pkg::LVL0_CODE);
        // Stimulus stands for status flag and enable both set
        preq[3:1] = 3'b111;
        take_is(16'hFFF6, 1'b1, 1'b0);
        check(last_take.vec, 4'h2);
        step(1);
        check(level, nic_pkg::LVL2_CODE);
        check(pending[3:1], 3'b101);
        step(10);
        check(take_req, 1'b0);
        ret_to(nic_pkg::LVL0_CODE);
        take_is(16'hFFF8, 1'b1, 1'b0);
        ret_to(nic_pkg::LVL0_CODE);
        take_is(16'hFFF4, 1'b1, 1'b0);
        preq[3] = 1'b0;
        step(1);
        preq[3] = 1'b1;
        step(4);
        check(take_req, 1'b0);
        prio_wr(2'h0, 8'h04);
        take_is(16'hFFF4, 1'b1, 1'b0);
        step(1);
        check(level, nic_pkg::LVL2_CODE);
        preq = 14'h0000;
        done("arbitration");
        sw_level(nic_pkg::LVL3_CODE);
        preq[1] = 1'b1;
        slow = 1'b1;
        trap = 1'b1;
        step(1);
        trap = 1'b0;
        take_is(16'hFFFC, 1'b1, 1'b1);
        step(1);
        check(level, nic_pkg::LVL3_CODE);
        ret_to(nic_pkg::LVL2_CODE);
        check(level, nic_pkg::LVL2_CODE);
        clr(1);
        check(pending[1], 1'b0);
        preq = 14'h0000;
        slow = 1'b0;
        done("trap");
        sw_level(nic_pkg::LVL0_CODE);
        src_en[3] = 1'b0;
        preq[3] = 1'b1;
        step(10);
        check({pending[3], take_req}, 2'b10);
        preq[3] = 1'b0;
        clr(3);
        check(pending[3], 1'b0);
        src_en[2] = 1'b0;
        sens[2] = 1'b0;
        ext_sel = 8'h06;
        ext_pin = 8'h01;
        step(5);
        check(pending[2], 1'b0);
        ext_pin = 8'h05;
        step(4);
        check(pending[2], 1'b1);
        ext_pin = 8'h00;
        step(3);
        clr(2);
        check(pending[2], 1'b0);
        sens[2] = 1'b1;
        src_en = 14'h3FFF;
        done("enable and pins");
        halt_mode = 1'b1;
        preq[8] = 1'b1;
        step(3);
        check(wake, 1'b0);
        preq[3] = 1'b1;
        step(3);
        check(wake, 1'b1);
        halt_mode = 1'b0;
        take_is(16'hFFF4, 1'b1, 1'b0);
        take_is(16'hFFEA, 1'b1, 1'b0);
        ret_to(nic_pkg::LVL0_CODE);
        preq = 14'h0000;
        wait_mode = 1'b1;
        step(1);
        preq[9] = 1'b1;
        step(3);
        check(wake, 1'b1);
        wait_mode = 1'b0;
        take_is(16'hFFE8, 1'b1, 1'b0);
        preq = 14'h0000;
        done("low power");
        finish_test();
    end
endmodule // tb_top
